// ---- tc_edge_det.sv ----
/*
  one trigger input: two-stage synchroniser followed by an edge qualifier
  with its own polarity setting.
  assumes pin_i is asynchronous to clk_i and pol_i is a stable register.
*/
`timescale 1ns/1ps
module tc_edge_det import tc_pkg::*; (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    pin_i,
  input  wire tc_pol_t pol_i,
  output logic         evt_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic evt;
  } tc_edge_st_t;

  tc_edge_st_t s;
  tc_edge_st_t next_s;

  // s1 feeds only s2; the edge compare looks at s2 and s3
  always_comb begin
    next_s    = s;
    next_s.s1 = pin_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    case (pol_i)
      POL_RISE: next_s.evt = s.s2 & ~s.s3;
      POL_FALL: next_s.evt = ~s.s2 & s.s3;
      POL_BOTH: next_s.evt = s.s2 ^ s.s3;
      default:  next_s.evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign evt_o = s.evt;

  property p_rise;
    @(posedge clk_i) disable iff (rst_i)
    (pol_i == POL_RISE && $past(pol_i) == POL_RISE && evt_o) |-> $past(s.s2) && !$past(s.s3);
  endproperty
  a_rise: assert property (p_rise) else $error("rise event without rising edge");

  property p_fall;
    @(posedge clk_i) disable iff (rst_i)
    (pol_i == POL_FALL && $past(pol_i) == POL_FALL && evt_o) |-> !$past(s.s2) && $past(s.s3);
  endproperty
  a_fall: assert property (p_fall) else $error("fall event without falling edge");

  property p_both;
    @(posedge clk_i) disable iff (rst_i)
    (pol_i == POL_BOTH && (s.s2 != s.s3)) |=> evt_o;
  endproperty
  a_both: assert property (p_both) else $error("edge missed in both-edge mode");

endmodule

// ---- tc_far_end.sv ----
/*
  far side model: trigger pin, button, event pin and a waveform player.
  assumes start_i is the block's one-cycle start pulse on clk_i.
*/
`timescale 1ns/1ps
module tc_far_end #(
  parameter int LEN = 40
) (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  output logic      [2:0] pins_o,
  output logic            done_o
);
  int left = 0;

  initial begin
    pins_o = 3'h0;
    done_o = 1'b0;
  end

  // ------------------------------------------------------------
  // player: a start reloads the length, so a restart replays it
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    done_o <= (left == 1);
    if (start_i === 1'b1) begin
      left <= LEN;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end

  // ------------------------------------------------------------
  // pins move off the edge, as a truly asynchronous source would
  // ------------------------------------------------------------
  task automatic pulse(input int which, input int hi);
    @(posedge clk_i);
    #3 pins_o[which] = 1'b1;
    repeat (hi) @(posedge clk_i);
    #3 pins_o[which] = 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ---- tc_pkg.sv ----
/*
  shared constants and types for the trigger control block: register map,
  field layouts, reset values, timing counts and the register bus carriers.
  assumes a 50 MHz sample clock and a 32-bit AXI4-Lite register bus.
*/
package tc_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int              ADDR_W   = 8;
  localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] A_SWTRIG = 8'h04;
  localparam logic [ADDR_W-1:0] A_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] A_GAP    = 8'h0C;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SWT_BIT     = 0;
  localparam int ST_PLAYING  = 0;
  localparam int ST_RUN      = 1;
  localparam int CTRL_W      = 9;

  // ------------------------------------------------------------------
  // timing: figures as printed, cycle counts derived from the clock
  // ------------------------------------------------------------------
  localparam int CLK_NS        = 20;
  localparam int T_PER_DEF_NS  = 15000;
  localparam int T_PER_MIN_NS  = 200;
  localparam int T_PER_MAX_S   = 20;
  localparam int PER_DEF_CYC   = T_PER_DEF_NS / CLK_NS;
  localparam int PER_MIN_CYC   = (T_PER_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PER_MAX_CYC   = T_PER_MAX_S * (1000000000 / CLK_NS);
  localparam int GAP_DEF       = 152;
  localparam int GAP_MIN       = 152;
  localparam int GAP_MAX       = 8000000;
  localparam int GAP_STEP      = 8;

  localparam logic [31:0] PER_RST = 32'(PER_DEF_CYC);
  localparam logic [31:0] GAP_RST = 32'(GAP_DEF);

  // ------------------------------------------------------------------
  // settings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {POL_RISE, POL_FALL, POL_BOTH} tc_pol_t;
  typedef enum logic [1:0] {SRC_EXT, SRC_BUS, SRC_TIMER, SRC_EVENT} tc_src_t;

  typedef struct packed {
    tc_pol_t evt_pol;
    logic    tmr_delay;
    tc_src_t src;
    tc_pol_t pol;
    logic    restart;
    logic    cont;
  } tc_ctrl_t;

  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // ------------------------------------------------------------------
  // register bus carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } tc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tc_axi_rsp_t;

endpackage

// ---- tc_trig_ctrl.sv ----
/*
  trigger control: picks a trigger source, qualifies edges, applies normal
  or restart handling and runs the internal periodic trigger generator.
  registers over AXI4-Lite. assumes wave_done_i is a one-cycle pulse from
  the waveform player on the same clock, marking the end of a waveform.
*/
`timescale 1ns/1ps

module tc_trig_ctrl import tc_pkg::*; (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire tc_axi_req_t  axi_req_i,
  output tc_axi_rsp_t       axi_rsp_o,
  input  wire logic         trig_pin_i,
  input  wire logic         button_i,
  input  wire logic         event_pin_i,
  input  wire logic         wave_done_i,
  output logic              start_o,
  output logic              run_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    tc_ctrl_t          ctrl;
    logic [31:0]       per;
    logic [31:0]       gap;
    logic [31:0]       tcnt;
    logic              playing;
    logic              start;
    logic              run;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } tc_state_t;

  tc_state_t   s;
  tc_state_t   next_s;
  logic [2:0]  pin_evt;
  logic [2:0]  pin_raw;
  tc_pol_t     pin_pol [3];
  logic        wr_fire;
  logic [31:0] ctrl_wr;
  logic        sw_pulse;
  logic        tmr_fire;
  logic        src_evt;
  logic        trig_acc;

  // ------------------------------------------------------------------
  // input qualification: trigger pin, button, event pin
  // ------------------------------------------------------------------
  assign pin_raw    = {event_pin_i, button_i, trig_pin_i};
  assign pin_pol[0] = s.ctrl.pol;
  // the button is a clean push, so only its press is taken
  assign pin_pol[1] = POL_RISE;
  assign pin_pol[2] = s.ctrl.evt_pol;

  for (genvar g = 0; g < 3; g++) begin : g_pin
    tc_edge_det u_edge (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (pin_raw[g]),
      .pol_i (pin_pol[g]),
      .evt_o (pin_evt[g])
    );
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // trigger selection and generator
  // ------------------------------------------------------------------
  assign wr_fire  = s.aw_got && s.w_got && !s.bvalid;
  assign sw_pulse = wr_fire && (s.awaddr == A_SWTRIG) && s.wstrb[0] && s.wdata[SWT_BIT];
  // only the low CTRL_W bits hold settings; the rest of the word is dropped
  assign ctrl_wr  = merge(32'(s.ctrl), s.wdata, s.wstrb);

  // without tmr_delay the generator runs on its own count; with it the count is held at zero while playing and restarts at the waveform end
  always_comb begin
    if (s.ctrl.tmr_delay) begin
      tmr_fire = !s.playing && (s.tcnt >= s.gap - 32'h0000_0001);
    end else begin
      tmr_fire = s.tcnt >= s.per - 32'h0000_0001;
    end
  end

  always_comb begin
    case (s.ctrl.src)
      SRC_EXT:   src_evt = pin_evt[0] | pin_evt[1];
      SRC_BUS:   src_evt = sw_pulse;
      SRC_TIMER: src_evt = tmr_fire;
      SRC_EVENT: src_evt = pin_evt[2];
      default:   src_evt = 1'b0;
    endcase
  end

  // in continuous mode no trigger gates the output
  assign trig_acc = !s.ctrl.cont && src_evt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // generator count
    if (tmr_fire || (s.ctrl.tmr_delay && s.playing)) begin
      next_s.tcnt = 32'h0000_0000;
    end else begin
      next_s.tcnt = s.tcnt + 32'h0000_0001;
    end

    // waveform control; a start wins over an end in the same cycle
    next_s.start = trig_acc && (s.ctrl.restart || !s.playing);
    if (s.ctrl.cont) begin
      next_s.playing = 1'b0;
    end else if (next_s.start) begin
      next_s.playing = 1'b1;
    end else if (wave_done_i) begin
      next_s.playing = 1'b0;
    end
    // write address and data, taken in either order
    if (axi_req_i.awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req_i.wdata;
      next_s.wstrb = axi_req_i.wstrb;
    end

    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      if (s.awaddr == A_CTRL) begin
        next_s.ctrl = tc_ctrl_t'(ctrl_wr[CTRL_W-1:0]);
      end else if (s.awaddr == A_SWTRIG) begin
        next_s.bresp = RESP_OKAY;
      end else if (s.awaddr == A_PERIOD) begin
        next_s.per = clamp(merge(s.per, s.wdata, s.wstrb),
                           32'(PER_MIN_CYC), 32'(PER_MAX_CYC));
      end else if (s.awaddr == A_GAP) begin
        // low bits dropped so the gap stays on the 8-point grid
        next_s.gap = clamp(merge(s.gap, s.wdata, s.wstrb),
                           32'(GAP_MIN), 32'(GAP_MAX))
                     & ~32'(GAP_STEP - 1);
      end else if (s.awaddr == A_STATUS) begin
        next_s.bresp = RESP_OKAY;
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end else if (s.bvalid && axi_req_i.bready) begin
      next_s.bvalid = 1'b0;
    end

    // entering continuous mode acts at once, so no start or playing state leaks out
    if (next_s.ctrl.cont) begin
      next_s.start   = 1'b0;
      next_s.playing = 1'b0;
    end
    next_s.run = next_s.ctrl.cont | next_s.playing;

    // read channel: answer one cycle after the address is taken
    if (axi_req_i.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      if (axi_req_i.araddr == A_CTRL) begin
        next_s.rdata = 32'(s.ctrl);
      end else if (axi_req_i.araddr == A_SWTRIG) begin
        next_s.rdata = 32'h0000_0000;
      end else if (axi_req_i.araddr == A_PERIOD) begin
        next_s.rdata = s.per;
      end else if (axi_req_i.araddr == A_GAP) begin
        next_s.rdata = s.gap;
      end else if (axi_req_i.araddr == A_STATUS) begin
        next_s.rdata = 32'h0000_0000;
        next_s.rdata[ST_PLAYING] = s.playing;
        next_s.rdata[ST_RUN]     = s.run;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = RESP_SLVERR;
      end
    end else if (s.rvalid && axi_req_i.rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.ctrl <= tc_ctrl_t'(CTRL_RST);
      s.per  <= PER_RST;
      s.gap  <= GAP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    axi_rsp_o         = '0;
    axi_rsp_o.awready = !s.aw_got && !s.bvalid;
    axi_rsp_o.wready  = !s.w_got && !s.bvalid;
    axi_rsp_o.bvalid  = s.bvalid;
    axi_rsp_o.bresp   = s.bresp;
    axi_rsp_o.arready = !s.rvalid;
    axi_rsp_o.rvalid  = s.rvalid;
    axi_rsp_o.rdata   = s.rdata;
    axi_rsp_o.rresp   = s.rresp;
  end

  assign start_o = s.start;
  assign run_o   = s.run;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_norm_ignore;
    @(posedge clk_i) disable iff (rst_i)
    (!s.ctrl.restart && s.playing && !wave_done_i && trig_acc) |=> !start_o && s.playing;
  endproperty
  a_norm_ignore: assert property (p_norm_ignore) else $error("trigger not ignored");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.restart && trig_acc && !next_s.ctrl.cont) |=> start_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart trigger lost");

  property p_ext;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.src == SRC_EXT && trig_acc) |-> (pin_evt[0] || pin_evt[1]);
  endproperty
  a_ext: assert property (p_ext) else $error("external source took a foreign trigger");

  property p_bus;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.src == SRC_BUS && !s.ctrl.cont && (pin_evt != 3'h0) && !sw_pulse) |-> !trig_acc;
  endproperty
  a_bus: assert property (p_bus) else $error("software source took a pin trigger");

  property p_timer;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.src == SRC_TIMER && trig_acc) |-> tmr_fire;
  endproperty
  a_timer: assert property (p_timer) else $error("internal source took a foreign trigger");

  property p_event;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.src == SRC_EVENT && trig_acc) |-> pin_evt[2];
  endproperty
  a_event: assert property (p_event) else $error("event source took a foreign trigger");

  property p_cont;
    @(posedge clk_i) disable iff (rst_i)
    s.ctrl.cont |-> run_o && !start_o && !s.playing;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode gated by trigger");

  property p_tmr_time;
    @(posedge clk_i) disable iff (rst_i)
    (!s.ctrl.tmr_delay && $stable(s.per) && tmr_fire) |=> s.tcnt == 32'h0000_0000 && !tmr_fire;
  endproperty
  a_tmr_time: assert property (p_tmr_time) else $error("timed generator did not reload");

  property p_tmr_gap;
    @(posedge clk_i) disable iff (rst_i)
    (s.ctrl.tmr_delay && s.playing) |=> s.tcnt == 32'h0000_0000;
  endproperty
  a_tmr_gap: assert property (p_tmr_gap) else $error("gap count ran during playback");

  property p_gap_range;
    @(posedge clk_i) disable iff (rst_i)
    s.gap >= 32'(GAP_MIN) && s.gap <= 32'(GAP_MAX) && s.gap[2:0] == 3'h0;
  endproperty
  a_gap_range: assert property (p_gap_range) else $error("gap out of range");

  c_norm_start: cover property (@(posedge clk_i) disable iff (rst_i)
    !s.ctrl.restart && !s.playing && trig_acc ##1 start_o);
  c_restart: cover property (@(posedge clk_i) disable iff (rst_i)
    s.ctrl.restart && s.playing && trig_acc);
  c_tmr_fire: cover property (@(posedge clk_i) disable iff (rst_i)
    s.ctrl.src == SRC_TIMER && tmr_fire && !s.ctrl.cont);
  c_wr: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && s.awaddr == A_CTRL);

endmodule

// ---- tc_trig_ctrl_test.sv ----
/*
  self-checking bench for the trigger control block.
  assumes the far side model tc_far_end and the tc_pkg register map.
*/
`timescale 1ns/1ps
module tc_trig_ctrl_test import tc_pkg::*; ;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  tc_axi_req_t req   = '0;
  tc_axi_rsp_t rsp;
  logic  [2:0] pins;
  logic        done;
  logic        start_o;
  logic        run_o;
  int          bad_count = 0;
  int          compares  = 0;
  int          starts    = 0;
  int          base;
  int          n;
  logic [33:0] notes[$];
  logic [31:0] rnd = 32'h0000_8e58;
  int          srcs[3] = '{0, 1, 3};
  int          exps[3] = '{3, 1, 1};
  int          pexp[3] = '{1, 1, 2};

  always #10 clk_i = ~clk_i;

  tc_trig_ctrl dut (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .axi_req_i   (req),
    .axi_rsp_o   (rsp),
    .trig_pin_i  (pins[0]),
    .button_i    (pins[1]),
    .event_pin_i (pins[2]),
    .wave_done_i (done),
    .start_o     (start_o),
    .run_o       (run_o)
  );

  tc_far_end far (
    .clk_i   (clk_i),
    .start_i (start_o),
    .pins_o  (pins),
    .done_o  (done)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic gap(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw;
    logic w;
    aw = 1'b0;
    w  = 1'b0;
    notes.push_back({e, 32'h0000_0000});
    // one edge between calls, so bready is never set twice in one step
    @(posedge clk_i);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    notes.push_back(e);
    @(posedge clk_i);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do @(posedge clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // result watcher: each bus answer takes the oldest note
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (start_o === 1'b1) starts <= starts + 1;
    if (rsp.bvalid === 1'b1 && req.bready) check({rsp.bresp, 32'h0000_0000}, notes.pop_front());
    if (rsp.rvalid === 1'b1 && req.rready) check({rsp.rresp, rsp.rdata}, notes.pop_front());
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    gap(2);
    rd(A_CTRL, {RESP_OKAY, 32'h0000_0000});
    rd(A_PERIOD, {RESP_OKAY, PER_RST});
    rd(A_GAP, {RESP_OKAY, GAP_RST});
    rd(A_SWTRIG, {RESP_OKAY, 32'h0000_0000});
    rd(8'h14, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h14, 32'h0000_0001, RESP_SLVERR);
    $display("register defaults done");
    base = starts;
    far.pulse(0, 4);
    gap(1);
    check(34'(run_o), 34'h0_0000_0001);
    far.pulse(0, 4);
    gap(1);
    check(34'(starts - base), 34'h0_0000_0001);
    gap(60);
    check(34'(run_o), 34'h0_0000_0000);
    wr(A_CTRL, 32'h0000_0002, RESP_OKAY);
    base = starts;
    far.pulse(0, 4);
    far.pulse(0, 4);
    gap(1);
    check(34'(starts - base), 34'h0_0000_0002);
    $display("normal and restart handling done");
    for (int p = 0; p < 3; p++) begin
      wr(A_CTRL, 32'((p << 2) | 2), RESP_OKAY);
      base = starts;
      far.pulse(0, 4);
      gap(1);
      check(34'(starts - base), 34'(pexp[p]));
    end
    $display("polarity done");
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, 32'((srcs[i] << 4) | 8 | 2), RESP_OKAY);
      base = starts;
      far.pulse(0, 4);
      far.pulse(1, 4);
      far.pulse(2, 4);
      wr(A_SWTRIG, 32'h0000_0001, RESP_OKAY);
      gap(4);
      check(34'(starts - base), 34'(exps[i]));
    end
    $display("sources done");
    wr(A_PERIOD, 32'h0000_000a, RESP_OKAY);
    rd(A_PERIOD, {RESP_OKAY, 32'h0000_000a});
    wr(A_CTRL, 32'h0000_0022, RESP_OKAY);
    gap(20);
    base = starts;
    fork
      gap(100);
      begin
        far.pulse(0, 4);
        far.pulse(2, 4);
      end
    join
    check(34'(starts - base), 34'h0_0000_000a);
    wr(A_CTRL, 32'h0000_0021, RESP_OKAY);
    gap(5);
    base = starts;
    far.pulse(0, 4);
    gap(100);
    check(34'(starts - base), 34'h0_0000_0000);
    check(34'(run_o), 34'h0_0000_0001);
    rd(A_STATUS, {RESP_OKAY, 32'h0000_0002});
    wr(A_CTRL, 32'h0000_0002, RESP_OKAY);
    gap(60);
    base = starts;
    gap(100);
    check(34'(starts - base), 34'h0_0000_0000);
    $display("timer and run mode done");
    // the bench keeps to the legal grid: in range, multiples of 8
    wr(A_GAP, 32'h0000_00a8, RESP_OKAY);
    rd(A_GAP, {RESP_OKAY, 32'h0000_00a8});
    wr(A_GAP, 32'h0000_0140, RESP_OKAY);
    rd(A_GAP, {RESP_OKAY, 32'h0000_0140});
    wr(A_GAP, 32'h0000_00a0, RESP_OKAY);
    wr(A_CTRL, 32'h0000_0060, RESP_OKAY);
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    check(34'(n < 1000), 34'h0_0000_0001);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (start_o !== 1'b1 && n < 400);
    #1;
    check(34'(n >= 158 && n <= 164), 34'h0_0000_0001);
    $display("end-to-start timer done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(A_CTRL, {23'h00_0000, rnd[8:0]}, RESP_OKAY);
      rd(A_CTRL, {RESP_OKAY, 23'h00_0000, rnd[8:0]});
    end
    $display("readback done");
    gap(4);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
